// file: logic/emtc_pkg.sv
// emtc_pkg: constants, states and carriers of the transmit framing and crc block.
// assumes one 100 MHz clock; byte-wide buffer and line interfaces outside.
package emtc_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_MAC_CTRL3 = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_MAX_LEN = 8'h08;
  localparam logic [7:0] OFF_TX_CMD = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFF_INFO = 8'h1C;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int PAD_CFG_LSB = 5;
  localparam int HUGE_BIT = 2;
  localparam int DISCARD_BIT = 0;
  localparam int START_BIT = 0;
  localparam logic [2:0] PAD_CFG_RST = 3'h0;
  localparam logic HUGE_RST = 1'b0;
  localparam logic DISCARD_RST = 1'b1;
  localparam logic [15:0] MAX_LEN_RST = 16'h05EE;

  // per-packet control byte
  localparam int PKT_SEL_BIT = 0;
  localparam int PKT_CRC_BIT = 1;
  localparam int PKT_PAD_BIT = 2;
  localparam int PKT_HUGE_BIT = 3;

  // interrupt status layout
  localparam int NUM_EV = 5;
  localparam int EV_TX_DONE = 0;
  localparam int EV_TX_GIANT = 1;
  localparam int EV_TX_FCS_BAD = 2;
  localparam int EV_RX_DONE = 3;
  localparam int EV_RX_CRC_ERR = 4;

  // ----------------------------------------
  // framing constants
  // ----------------------------------------
  localparam logic [2:0] PRE_LAST = 3'h7;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [15:0] MIN_BODY = 16'h003C;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_CTRL = 3'b001,
    TX_PRE = 3'b011,
    TX_DATA = 3'b010,
    TX_PAD = 3'b110,
    TX_FCS = 3'b111,
    TX_DONE = 3'b101,
    TX_DRAIN = 3'b100
  } emtc_tx_state_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } emtc_mem_rsp_t;

  typedef struct packed {
    logic en;
    logic valid;
    logic [7:0] data;
  } emtc_tx_out_t;

  typedef struct packed {
    logic dv;
    logic valid;
    logic [7:0] data;
  } emtc_rx_in_t;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } emtc_rx_wr_t;

  typedef struct packed {
    logic done;
    logic commit;
    logic crc_ok;
  } emtc_rx_end_t;

endpackage

// file: logic/emtc_crc32.sv
// emtc_crc32: byte-serial reflected crc-32 register.
// assumes init and en come from logic on the same clock.
`timescale 1ns/1ps
module emtc_crc32 (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control and data
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  // running remainder, not inverted
  output logic [31:0] crc_reg
);

  logic [31:0] crc_next;

  // init with en folds the first byte in, so a frame can start on any cycle
  always_comb begin
    logic [31:0] c;
    c = init ? emtc_pkg::CRC_INIT : crc_reg;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ emtc_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    if (en) begin
      crc_next = c;
    end else if (init) begin
      crc_next = emtc_pkg::CRC_INIT;
    end else begin
      crc_next = crc_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_reg <= emtc_pkg::CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

endmodule // emtc_crc32

// file: logic/emtc_top.sv
// emtc_top: transmit framing with pad and crc, receive crc check, ahb-lite registers.
// assumes a buffer reader answering byte requests and a line serialiser that
// pulses phy_tx_take when it has taken the presented byte.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

// Functional notes
// - fcs is crc-32 over header, data, pad
// - every received frame has its crc checked
// - discard on: bad-crc frame never committed
// - discard off: kept, crc validity reported
// - append crc when configured, else host supplies
// - preamble and delimiter generated, never fetched
// - one control byte precedes each frame
// - bit 3 oversize allow, only when overriding
// - oversize blocked: abort at max length
// - bit 2 pads short frames with zeros
// - padding brings frame body to 60 bytes
// - global pad/crc field in bits 7:5
module emtc_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt
  output logic irq,
  // transmit buffer reader
  output logic mem_rd_req,
  input wire emtc_pkg::emtc_mem_rsp_t mem_rd_rsp,
  // line transmit side
  output emtc_pkg::emtc_tx_out_t tx_out,
  input wire logic phy_tx_take,
  // line receive side and receive buffer writer
  input wire emtc_pkg::emtc_rx_in_t rx_in,
  output emtc_pkg::emtc_rx_wr_t rx_wr,
  output emtc_pkg::emtc_rx_end_t rx_end
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0] pad_cfg_reg;
  logic huge_reg;
  logic discard_reg;
  logic [15:0] max_len_reg;
  logic [emtc_pkg::NUM_EV-1:0] sts_reg;
  logic [emtc_pkg::NUM_EV-1:0] ien_reg;
  logic [emtc_pkg::NUM_EV-1:0] ev;
  logic irq_reg;
  logic ph_wr_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] hrdata_reg;
  emtc_pkg::emtc_tx_state_t st_reg;
  logic [2:0] pre_cnt_reg;
  logic [1:0] fcs_cnt_reg;
  logic [15:0] byte_cnt_reg;
  logic [15:0] last_len_reg;
  logic eff_pad_reg;
  logic eff_crc_reg;
  logic eff_huge_reg;
  logic giant_reg;
  logic [7:0] hold_reg;
  logic hold_v_reg;
  logic hold_last_reg;
  logic rd_req_reg;
  emtc_pkg::emtc_tx_out_t tx_out_reg;
  logic tx_done_p_reg;
  logic giant_p_reg;
  logic fcs_bad_p_reg;
  logic rx_dv_d_reg;
  logic rx_ok_last_reg;
  logic rx_done_p_reg;
  logic rx_bad_p_reg;
  emtc_pkg::emtc_rx_wr_t rx_wr_reg;
  emtc_pkg::emtc_rx_end_t rx_end_reg;
  logic [31:0] tx_crc;
  logic [31:0] rx_crc;

  logic addr_ph;
  logic slot;
  logic start_cmd;
  logic [emtc_pkg::NUM_EV-1:0] clr_mask;
  logic [15:0] cnt_inc;
  logic tx_crc_en;
  logic rx_crc_ok;
  logic rx_ends;

  assign addr_ph = hsel && htrans[1] && hready;
  // the output byte slot is free when empty or being taken this cycle
  assign slot = !tx_out_reg.valid || phy_tx_take;
  assign start_cmd = ph_wr_reg && (ph_addr_reg == emtc_pkg::OFF_TX_CMD)
                     && hwdata[emtc_pkg::START_BIT];
  assign clr_mask = (ph_wr_reg && (ph_addr_reg == emtc_pkg::OFF_IRQ_CLEAR))
                    ? hwdata[emtc_pkg::NUM_EV-1:0] : '0;
  assign cnt_inc = byte_cnt_reg + 16'h0001;
  assign ev = {rx_bad_p_reg, rx_done_p_reg, fcs_bad_p_reg, giant_p_reg, tx_done_p_reg};
  assign rx_crc_ok = (rx_crc == emtc_pkg::CRC_RESIDUE);
  assign rx_ends = !rx_in.dv && rx_dv_d_reg;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign irq = irq_reg;
  assign mem_rd_req = rd_req_reg;
  assign tx_out = tx_out_reg;
  assign rx_wr = rx_wr_reg;
  assign rx_end = rx_end_reg;

  // ----------------------------------------
  // crc engines
  // ----------------------------------------
  assign tx_crc_en = slot && (((st_reg == emtc_pkg::TX_DATA) && hold_v_reg)
                     || (st_reg == emtc_pkg::TX_PAD));

  emtc_crc32 u_tx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(st_reg == emtc_pkg::TX_CTRL),
    .en(tx_crc_en),
    .data((st_reg == emtc_pkg::TX_PAD) ? 8'h00 : hold_reg),
    .crc_reg(tx_crc)
  );

  emtc_crc32 u_rx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(rx_in.dv && !rx_dv_d_reg),
    .en(rx_in.dv && rx_in.valid),
    .data(rx_in.data),
    .crc_reg(rx_crc)
  );

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      ph_wr_reg <= addr_ph && hwrite && (haddr[31:8] == 24'h000000);
      ph_addr_reg <= haddr[7:0];
      // read data is latched at the address phase; unmapped reads give zero
      hrdata_reg <= 32'h00000000;
      if (addr_ph && !hwrite && (haddr[31:8] == 24'h000000)) begin
        case (haddr[7:0])
          emtc_pkg::OFF_MAC_CTRL3: begin
            hrdata_reg[emtc_pkg::PAD_CFG_LSB +: 3] <= pad_cfg_reg;
            hrdata_reg[emtc_pkg::HUGE_BIT] <= huge_reg;
          end
          emtc_pkg::OFF_RX_CTRL: hrdata_reg[emtc_pkg::DISCARD_BIT] <= discard_reg;
          emtc_pkg::OFF_MAX_LEN: hrdata_reg[15:0] <= max_len_reg;
          emtc_pkg::OFF_IRQ_STATUS: hrdata_reg[emtc_pkg::NUM_EV-1:0] <= sts_reg;
          emtc_pkg::OFF_IRQ_ENABLE: hrdata_reg[emtc_pkg::NUM_EV-1:0] <= ien_reg;
          emtc_pkg::OFF_INFO: hrdata_reg <= {last_len_reg, 13'h0000, giant_reg,
                                             rx_ok_last_reg, st_reg != emtc_pkg::TX_IDLE};
          default: hrdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_cfg_reg <= emtc_pkg::PAD_CFG_RST;
      huge_reg <= emtc_pkg::HUGE_RST;
      discard_reg <= emtc_pkg::DISCARD_RST;
      max_len_reg <= emtc_pkg::MAX_LEN_RST;
      ien_reg <= '0;
    end else if (ph_wr_reg) begin
      case (ph_addr_reg)
        emtc_pkg::OFF_MAC_CTRL3: begin
          pad_cfg_reg <= hwdata[emtc_pkg::PAD_CFG_LSB +: 3];
          huge_reg <= hwdata[emtc_pkg::HUGE_BIT];
        end
        emtc_pkg::OFF_RX_CTRL: discard_reg <= hwdata[emtc_pkg::DISCARD_BIT];
        emtc_pkg::OFF_MAX_LEN: max_len_reg <= hwdata[15:0];
        emtc_pkg::OFF_IRQ_ENABLE: ien_reg <= hwdata[emtc_pkg::NUM_EV-1:0];
        default: ien_reg <= ien_reg;
      endcase
    end
  end

  // ----------------------------------------
  // interrupts: a new event wins over a clear in the same cycle
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= (sts_reg & ~clr_mask) | ev;
      irq_reg <= |(((sts_reg & ~clr_mask) | ev) & ien_reg);
    end
  end

  // ----------------------------------------
  // transmit engine
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= emtc_pkg::TX_IDLE;
      pre_cnt_reg <= 3'h0;
      fcs_cnt_reg <= 2'h0;
      byte_cnt_reg <= 16'h0000;
      last_len_reg <= 16'h0000;
      eff_pad_reg <= 1'b0;
      eff_crc_reg <= 1'b0;
      eff_huge_reg <= 1'b0;
      giant_reg <= 1'b0;
      hold_reg <= 8'h00;
      hold_v_reg <= 1'b0;
      hold_last_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      tx_out_reg <= '0;
      tx_done_p_reg <= 1'b0;
      giant_p_reg <= 1'b0;
      fcs_bad_p_reg <= 1'b0;
    end else begin
      rd_req_reg <= 1'b0;
      tx_done_p_reg <= 1'b0;
      giant_p_reg <= 1'b0;
      fcs_bad_p_reg <= 1'b0;
      if (phy_tx_take) begin
        tx_out_reg.valid <= 1'b0;
      end
      case (st_reg)
        emtc_pkg::TX_IDLE: begin
          if (start_cmd) begin
            rd_req_reg <= 1'b1;
            giant_reg <= 1'b0;
            st_reg <= emtc_pkg::TX_CTRL;
          end
        end
        emtc_pkg::TX_CTRL: begin
          // control byte is consumed here and never reaches the line
          if (hold_v_reg) begin
            hold_v_reg <= 1'b0;
            if (hold_reg[emtc_pkg::PKT_SEL_BIT]) begin
              eff_pad_reg <= hold_reg[emtc_pkg::PKT_PAD_BIT];
              eff_crc_reg <= hold_reg[emtc_pkg::PKT_CRC_BIT];
              eff_huge_reg <= hold_reg[emtc_pkg::PKT_HUGE_BIT];
            end else begin
              eff_pad_reg <= pad_cfg_reg[0];
              eff_crc_reg <= pad_cfg_reg != 3'h0;
              eff_huge_reg <= huge_reg;
            end
            pre_cnt_reg <= 3'h0;
            fcs_cnt_reg <= 2'h0;
            byte_cnt_reg <= 16'h0000;
            st_reg <= emtc_pkg::TX_PRE;
          end
        end
        emtc_pkg::TX_PRE: begin
          if (slot) begin
            tx_out_reg.data <= (pre_cnt_reg == emtc_pkg::PRE_LAST)
                               ? emtc_pkg::SFD_BYTE : emtc_pkg::PRE_BYTE;
            tx_out_reg.valid <= 1'b1;
            tx_out_reg.en <= 1'b1;
            pre_cnt_reg <= pre_cnt_reg + 3'h1;
            if (pre_cnt_reg == emtc_pkg::PRE_LAST) begin
              rd_req_reg <= 1'b1;
              st_reg <= emtc_pkg::TX_DATA;
            end
          end
        end
        emtc_pkg::TX_DATA: begin
          if (hold_v_reg && slot) begin
            hold_v_reg <= 1'b0;
            tx_out_reg.data <= hold_reg;
            tx_out_reg.valid <= 1'b1;
            byte_cnt_reg <= cnt_inc;
            if (!eff_huge_reg && !hold_last_reg && (cnt_inc >= max_len_reg)) begin
              giant_reg <= 1'b1;
              giant_p_reg <= 1'b1;
              rd_req_reg <= 1'b1;
              st_reg <= emtc_pkg::TX_DRAIN;
            end else if (hold_last_reg) begin
              if (eff_pad_reg && (cnt_inc < emtc_pkg::MIN_BODY)) begin
                st_reg <= emtc_pkg::TX_PAD;
              end else if (eff_crc_reg) begin
                st_reg <= emtc_pkg::TX_FCS;
              end else begin
                st_reg <= emtc_pkg::TX_DONE;
              end
            end else begin
              rd_req_reg <= 1'b1;
            end
          end
        end
        emtc_pkg::TX_PAD: begin
          if (slot) begin
            tx_out_reg.data <= 8'h00;
            tx_out_reg.valid <= 1'b1;
            byte_cnt_reg <= cnt_inc;
            if (cnt_inc >= emtc_pkg::MIN_BODY) begin
              st_reg <= eff_crc_reg ? emtc_pkg::TX_FCS : emtc_pkg::TX_DONE;
            end
          end
        end
        emtc_pkg::TX_FCS: begin
          if (slot) begin
            tx_out_reg.data <= ~tx_crc[{fcs_cnt_reg, 3'b000} +: 8];
            tx_out_reg.valid <= 1'b1;
            fcs_cnt_reg <= fcs_cnt_reg + 2'h1;
            if (fcs_cnt_reg == emtc_pkg::FCS_LAST) begin
              st_reg <= emtc_pkg::TX_DONE;
            end
          end
        end
        emtc_pkg::TX_DRAIN: begin
          // an aborted frame is read to its end so the next control byte lines up
          if (slot) begin
            tx_out_reg.en <= 1'b0;
          end
          if (hold_v_reg) begin
            hold_v_reg <= 1'b0;
            if (hold_last_reg) begin
              st_reg <= emtc_pkg::TX_DONE;
            end else begin
              rd_req_reg <= 1'b1;
            end
          end
        end
        emtc_pkg::TX_DONE: begin
          if (slot) begin
            tx_out_reg.en <= 1'b0;
            tx_done_p_reg <= 1'b1;
            last_len_reg <= byte_cnt_reg;
            // host-supplied fcs is checked as the tail of the frame
            fcs_bad_p_reg <= !eff_crc_reg && !giant_reg
                             && (tx_crc != emtc_pkg::CRC_RESIDUE);
            st_reg <= emtc_pkg::TX_IDLE;
          end
        end
        default: st_reg <= emtc_pkg::TX_IDLE;
      endcase
      // one request is outstanding at a time, so an answer never meets a consume
      if (mem_rd_rsp.valid) begin
        hold_reg <= mem_rd_rsp.data;
        hold_last_reg <= mem_rd_rsp.last;
        hold_v_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // receive crc check and commit decision
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_dv_d_reg <= 1'b0;
      rx_ok_last_reg <= 1'b0;
      rx_done_p_reg <= 1'b0;
      rx_bad_p_reg <= 1'b0;
      rx_wr_reg <= '0;
      rx_end_reg <= '0;
    end else begin
      rx_dv_d_reg <= rx_in.dv;
      rx_wr_reg.wr <= rx_in.dv && rx_in.valid;
      rx_wr_reg.data <= rx_in.data;
      rx_end_reg.done <= rx_ends;
      rx_done_p_reg <= rx_ends;
      rx_bad_p_reg <= rx_ends && !rx_crc_ok;
      if (rx_ends) begin
        rx_end_reg.crc_ok <= rx_crc_ok;
        // the writer rewinds on a missing commit, so a dropped frame never lands
        rx_end_reg.commit <= rx_crc_ok || !discard_reg;
        rx_ok_last_reg <= rx_crc_ok;
      end
    end
  end

endmodule // emtc_top

// file: bench/emtc_top_monitor.sv
// emtc_top_monitor: concurrent checks on the framing block's ports.
// assumes one clock domain; bound onto emtc_top from the bench top file.
`timescale 1ns/1ps
module emtc_top_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // buffer and line
  input wire logic mem_rd_req,
  input wire emtc_pkg::emtc_tx_out_t tx_out,
  input wire logic phy_tx_take,
  input wire emtc_pkg::emtc_rx_in_t rx_in,
  input wire emtc_pkg::emtc_rx_wr_t rx_wr,
  input wire emtc_pkg::emtc_rx_end_t rx_end
);
  // ----------------------------------------
  // line bytes taken so far in this frame, counting stops at 8 after the delimiter
  // ----------------------------------------
  logic [3:0] pre_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= 4'h0;
    end else if (!tx_out.en) begin
      pre_cnt <= 4'h0;
    end else if (tx_out.valid && phy_tx_take && pre_cnt < 4'h8) begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // start is only written while the engine is idle, so en low is enough here
  sequence s_start;
    hsel && htrans[1] && hwrite && haddr == {24'h0, emtc_pkg::OFF_TX_CMD} && !tx_out.en
      ##1 hwdata[0];
  endsequence
  sequence s_dv_end;
    rx_in.dv ##1 !rx_in.dv;
  endsequence

  AST_START_FETCH: assert property (s_start |-> ##[1:2] mem_rd_req)
    else $error("no control byte fetch after start");
  AST_REQ_PULSE: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("buffer request longer than one cycle");
  AST_PREAMBLE: assert property (tx_out.en && tx_out.valid && pre_cnt < 4'h8 |->
    tx_out.data == (pre_cnt == 4'h7 ? emtc_pkg::SFD_BYTE : emtc_pkg::PRE_BYTE))
    else $error("preamble or delimiter byte wrong");
  AST_VALID_IN_FRAME: assert property (tx_out.valid |-> tx_out.en)
    else $error("line byte outside frame");
  AST_BYTE_HOLD: assert property (tx_out.valid && !phy_tx_take |=>
    tx_out.valid && $stable(tx_out.data))
    else $error("line byte changed before take");
  AST_RX_STORE: assert property (rx_in.dv && rx_in.valid |=>
    rx_wr.wr && rx_wr.data == $past(rx_in.data))
    else $error("received byte not written");
  AST_RX_DONE: assert property (s_dv_end |=> rx_end.done)
    else $error("no frame end after receive");
  AST_GOOD_COMMIT: assert property (rx_end.done && rx_end.crc_ok |-> rx_end.commit)
    else $error("good frame not committed");
  AST_RX_HOLD: assert property (!rx_end.done |-> $stable({rx_end.commit, rx_end.crc_ok}))
    else $error("receive result changed between frames");
endmodule // emtc_top_monitor

// file: bench/emtc_phy_model.sv
// emtc_phy_model: line side stand-in, takes transmit bytes at a random pace
// and plays receive frames; assumes one byte presented at a time.
`timescale 1ns/1ps
module emtc_phy_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line transmit side
  input wire emtc_pkg::emtc_tx_out_t tx_out,
  output logic phy_tx_take,
  // line receive side
  output emtc_pkg::emtc_rx_in_t rx_in
);
  logic [7:0] got[$];

  initial begin
    phy_tx_take = 1'b0;
    rx_in = '0;
  end

  // no take right after a take: the old byte is still seen at that edge
  always @(posedge hclk) begin
    phy_tx_take <= 1'b0;
    if (hresetn && tx_out.valid === 1'b1 && !phy_tx_take && $urandom_range(1, 0) == 1) begin
      phy_tx_take <= 1'b1;
      got.push_back(tx_out.data);
    end
  end

  // idle data shows the inverse of the last byte, never a stale copy
  task automatic send_frame(input logic [7:0] q[$]);
    repeat (2) @(posedge hclk);
    foreach (q[i]) begin
      @(posedge hclk);
      rx_in <= '{1'b1, 1'b1, q[i]};
    end
    @(posedge hclk);
    rx_in <= '{1'b0, 1'b0, ~q[q.size() - 1]};
  endtask
endmodule // emtc_phy_model

// file: bench/test_eth_mac_tx_framing_crc.sv
// test_eth_mac_tx_framing_crc: self-checking bench for emtc_top.
// assumes emtc_pkg compiled first; buffer responder and line model beside.
`timescale 1ns/1ps
module test_eth_mac_tx_framing_crc;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, mem_rd_req, phy_tx_take;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  emtc_pkg::emtc_mem_rsp_t mem_rd_rsp;
  emtc_pkg::emtc_tx_out_t tx_out;
  emtc_pkg::emtc_rx_in_t rx_in;
  emtc_pkg::emtc_rx_wr_t rx_wr;
  emtc_pkg::emtc_rx_end_t rx_end;
  logic [7:0] mq[$];
  int mi, wr_cnt, cycles, mismatches, num_checks;
  logic [7:0] ra[6] = '{emtc_pkg::OFF_MAC_CTRL3, emtc_pkg::OFF_RX_CTRL, emtc_pkg::OFF_MAX_LEN,
    emtc_pkg::OFF_IRQ_STATUS, emtc_pkg::OFF_IRQ_ENABLE, 8'h20};
  logic [31:0] rv[6] = '{32'h0, 32'h1, 32'h5EE, 32'h0, 32'h0, 32'h0};

  emtc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .mem_rd_req(mem_rd_req),
    .mem_rd_rsp(mem_rd_rsp), .tx_out(tx_out), .phy_tx_take(phy_tx_take), .rx_in(rx_in),
    .rx_wr(rx_wr), .rx_end(rx_end));
  emtc_phy_model phy (.hclk(hclk), .hresetn(hresetn), .tx_out(tx_out),
    .phy_tx_take(phy_tx_take), .rx_in(rx_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------
  // buffer reader, hang guard, write counter
  // ----------------------------------------
  always @(posedge hclk) begin
    mem_rd_rsp <= '{1'b0, 1'b0, ~mem_rd_rsp.data};
    if (mem_rd_req === 1'b1 && mi < mq.size()) begin
      mem_rd_rsp <= '{1'b1, mi == mq.size() - 1, mq[mi]};
      mi <= mi + 1;
    end
    if (rx_wr.wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk("register", e, r);
  endtask

  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction

  // reference frame built from the control byte and the global field
  task automatic tx_case(input logic [2:0] glob, input logic [7:0] ctrl, input int len,
                         input logic host_fcs, input logic giant);
    logic [7:0] body[$];
    logic [7:0] exp_q[$];
    logic [31:0] c, r;
    logic pad, crc;
    int k;
    pad = ctrl[0] ? ctrl[2] : glob[0];
    crc = ctrl[0] ? ctrl[1] : (glob != 3'h0);
    for (int i = 0; i < len; i++) begin
      body.push_back(8'($urandom));
    end
    c = crc_of(body);
    for (int i = 0; i < 4 && host_fcs; i++) begin
      body.push_back(c[8*i +: 8]);
    end
    mq = {ctrl, body};
    mi = 0;
    while (pad && body.size() < 60) begin
      body.push_back(8'h00);
    end
    c = crc_of(body);
    for (int i = 0; i < 4 && crc; i++) begin
      body.push_back(c[8*i +: 8]);
    end
    exp_q = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5, body};
    phy.got = {};
    wr(emtc_pkg::OFF_IRQ_CLEAR, 32'h1F);
    wr(emtc_pkg::OFF_MAC_CTRL3, {24'h0, glob, 5'h0});
    wr(emtc_pkg::OFF_TX_CMD, 32'h1);
    k = 0;
    while (tx_out.en !== 1'b1 && k < 100) begin
      @(negedge hclk);
      k++;
    end
    r = 32'h1;
    while (r[0] !== 1'b0 && k < 900) begin
      ahb(1'b0, emtc_pkg::OFF_INFO, 32'h0, r);
      k++;
    end
    // body count excludes generated fcs; a poll that ran out leaves busy set here
    chk("tx info", {16'(giant ? 20 : exp_q.size() - 8 - 4 * crc), 13'h0, giant, 2'b0},
        r & 32'hFFFF0005);
    ahb(1'b0, emtc_pkg::OFF_IRQ_STATUS, 32'h0, r);
    if (giant) begin
      chk("giant status", 32'h3, r & 32'h3);
      chk("cut frame", 32'h1C, 32'(phy.got.size()));
    end else begin
      chk("tx status", {29'h0, !crc && !host_fcs, 2'b01}, r & 32'h7);
      chk("wire length", 32'(exp_q.size()), 32'(phy.got.size()));
      foreach (exp_q[i]) begin
        chk("wire byte", 32'(exp_q[i]), 32'(phy.got[i]));
      end
    end
    $display("test tx ctrl %h field %h done", ctrl, glob);
  endtask

  task automatic rx_case(input logic bad, input logic commit);
    logic [7:0] f[$];
    logic [31:0] c;
    int k;
    for (int i = 0; i < 20; i++) begin
      f.push_back(8'($urandom));
    end
    c = crc_of(f);
    for (int i = 0; i < 4; i++) begin
      f.push_back(c[8*i +: 8] ^ {7'h0, bad && i == 3});
    end
    wr_cnt = 0;
    phy.send_frame(f);
    k = 0;
    while (rx_end.done !== 1'b1 && k < 20) begin
      @(negedge hclk);
      k++;
    end
    chk("rx crc ok", 32'(!bad), 32'(rx_end.crc_ok));
    chk("rx commit", 32'(commit), 32'(rx_end.commit));
    chk("rx bytes", 32'h18, 32'(wr_cnt));
    // status and irq follow the done pulse by one cycle
    @(negedge hclk);
    $display("test rx bad %b done", bad);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    mem_rd_rsp = '0;
    {cycles, mismatches, num_checks, mi, wr_cnt} = '0;
    void'($urandom(42));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h20, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], rv[i]);
    end
    chk("irq reset", 32'h0, 32'(irq));
    $display("test registers done");
    tx_case(3'h1, 8'h0E, 14, 1'b0, 1'b0);
    tx_case(3'h0, 8'hF7, 14, 1'b0, 1'b0);
    tx_case(3'h1, 8'h03, 14, 1'b0, 1'b0);
    tx_case(3'h6, 8'h00, 14, 1'b0, 1'b0);
    tx_case(3'h0, 8'h05, 10, 1'b0, 1'b0);
    tx_case(3'h1, 8'h00, 59, 1'b0, 1'b0);
    tx_case(3'h1, 8'h01, 12, 1'b1, 1'b0);
    wr(emtc_pkg::OFF_MAX_LEN, 32'h14);
    rd(emtc_pkg::OFF_MAX_LEN, 32'h14);
    tx_case(3'h0, 8'h09, 30, 1'b0, 1'b0);
    tx_case(3'h0, 8'h08, 30, 1'b0, 1'b1);
    wr(emtc_pkg::OFF_IRQ_ENABLE, 32'h10);
    rx_case(1'b0, 1'b1);
    chk("irq masked", 32'h0, 32'(irq));
    rx_case(1'b1, 1'b0);
    chk("irq raised", 32'h1, 32'(irq));
    wr(emtc_pkg::OFF_IRQ_CLEAR, 32'h1F);
    @(negedge hclk);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(emtc_pkg::OFF_RX_CTRL, 32'h0);
    rx_case(1'b1, 1'b1);
    wrap_up();
  end
endmodule // test_eth_mac_tx_framing_crc

bind emtc_top emtc_top_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .mem_rd_req(mem_rd_req),
  .tx_out(tx_out), .phy_tx_take(phy_tx_take), .rx_in(rx_in), .rx_wr(rx_wr), .rx_end(rx_end));
